// ---- design/gcm_monitor_engine.sv ----
// Monitor channel handshake engine with voice slot placement, top level
//
// Operation
// - 16 kHz 8-bit samples travel as two samples in both voice slots.
// - 16 kHz 16-bit samples use both slots of two consecutive sub-frames.
// - Receive handshake is bit 1, transmit handshake bit 0 of control byte.
// - Handshakes are active low; both high two frames means idle.
// - Host transmit handshake going low starts byte acceptance.
// - Receive handshake goes low in the frame after the byte arrives.
// - Receive handshake stays low until next byte or end of message.
// - Two or more high frames downstream mark end of message.
// - Writes use host transmit and device receive handshakes; reads swap.
// - Receiving side places all ones in its monitor byte every frame.
// - Device aborts its transmission on a non all-ones downstream monitor byte.
// - Register address increments after every register access.
// - Bursts continue until the address reaches an invalid register.
// - Abort holds receive handshake high at least two frames.
// - Abort on bad address, bad sequence, missing byte, or collision.
// - Bad command sequence abort changes no state or register.
// - Accesses done before an invalid address stay in effect.
// - End of message before a full command returns idle unchanged.
// - A byte is acknowledged only after two identical consecutive copies.
// - Host raising transmit handshake before validation causes abort.
// - Sub-frame holds two voice slots, monitor byte and control byte.
// - Frames last 125 us and start at frame sync rising edge.
`timescale 1ns/1ps
module gcm_monitor_engine import gcm_pkg::*; (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Highway link clock and pins
  input wire logic link_clk,
  input wire logic frame_sync,
  input wire logic highway_receive_line,
  output logic highway_transmit_line,
  output logic highway_transmit_oe,
  input wire logic [2:0] subframe_sel,
  // Voice mode and samples
  input wire logic rate_16k,
  input wire logic linear_16,
  input wire logic [15:0] voice_tx_first,
  input wire logic [15:0] voice_tx_second,
  output logic [15:0] voice_rx_first,
  output logic [15:0] voice_rx_second,
  output logic voice_strobe,
  // Register file access
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_addr_valid,
  // Status
  output logic abort_indication,
  output logic end_of_message,
  output logic message_active
);
  logic [47:0] up_bytes;
  logic [47:0] dn_bytes;
  logic frame_tgl;
  logic fev;

  gcm_rx_state_t rx_st_ff, nxt_rx_st;
  gcm_tx_state_t tx_st_ff, nxt_tx_st;
  logic [7:0] ll_ff, nxt_ll;
  logic [1:0] idx_ff, nxt_idx;
  logic [7:0] dev_ff, nxt_dev;
  logic rw_ff, nxt_rw;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [1:0] hcnt_ff, nxt_hcnt;
  logic [1:0] mcnt_ff, nxt_mcnt;
  logic [1:0] ecnt_ff, nxt_ecnt;
  logic seen_ff, nxt_seen;
  logic mr_ff, nxt_mr;
  logic mx_ff, nxt_mx;
  logic [7:0] mon_ff, nxt_mon;
  logic abort_ff, nxt_abort;
  logic eom_ff, nxt_eom;
  logic wr_ff, nxt_wr;
  logic rd_ff, nxt_rd;
  logic wide_ff;
  logic strobe_ff;
  logic [7:0] v_b1_ff;
  logic [7:0] v_b2_ff;
  logic [7:0] v_b1n_ff;
  logic [7:0] v_b2n_ff;
  logic [15:0] rx_first_ff;
  logic [15:0] rx_second_ff;

  // ****************************************
  // Link side and crossing
  // ****************************************
  gcm_link_framer u_framer (
    .link_clk(link_clk),
    .reset(reset),
    .frame_sync(frame_sync),
    .highway_receive_line(highway_receive_line),
    .highway_transmit_line(highway_transmit_line),
    .highway_transmit_oe(highway_transmit_oe),
    .subframe_sel(subframe_sel),
    .wide_mode(wide_ff),
    .up_bytes(up_bytes),
    .dn_bytes(dn_bytes),
    .frame_tgl(frame_tgl)
  );

  // Downstream bytes stay put for most of a frame after the toggle lands
  gcm_toggle_sync u_frame_sync (
    .clk(clk),
    .reset(reset),
    .tgl_in(frame_tgl),
    .pulse(fev)
  );

  // ****************************************
  // Downstream decode
  // ****************************************
  wire [7:0] dn_mon = dn_bytes[8*LB_MON +: 8];
  wire [7:0] dn_sc = dn_bytes[8*LB_SC +: 8];
  wire dn_mr = dn_sc[HS_MR];
  wire dn_mx = dn_sc[HS_MX];
  wire dn_quiet = dn_mr & dn_mx;
  wire same_copy = dn_mon == ll_ff;
  wire dev_ok = dn_mon[7:5] == DEV_TOP && dn_mon[2:1] == DEV_MID && dn_mon[DEV_NORMAL];
  wire cmd_ok = dn_mon[6:0] == CMD_REG;
  wire collision = dn_mon != MON_IDLE;
  wire [7:0] up_sc = {CI_IDLE, mr_ff, mx_ff};

  assign up_bytes = {v_b2n_ff, v_b1n_ff, up_sc, mon_ff, v_b2_ff, v_b1_ff};

  // ****************************************
  // Voice slot mapping
  // ****************************************
  wire wide = rate_16k & linear_16;
  wire [7:0] tx_b1 = voice_tx_first[15:8];
  wire [7:0] tx_b2 = linear_16 ? voice_tx_first[7:0] : voice_tx_second[15:8];
  wire [7:0] rx_b1 = dn_bytes[8*LB_B1 +: 8];
  wire [7:0] rx_b2 = dn_bytes[8*LB_B2 +: 8];
  wire [7:0] rx_b1n = dn_bytes[8*LB_B1N +: 8];
  wire [7:0] rx_b2n = dn_bytes[8*LB_B2N +: 8];
  wire [15:0] rx_first = linear_16 ? {rx_b1, rx_b2} : {rx_b1, 8'h00};
  wire [15:0] rx_second = wide ? {rx_b1n, rx_b2n} : {rx_b2, 8'h00};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wide_ff <= 1'b0;
      strobe_ff <= 1'b0;
      v_b1_ff <= BYTE_IDLE;
      v_b2_ff <= BYTE_IDLE;
      v_b1n_ff <= BYTE_IDLE;
      v_b2n_ff <= BYTE_IDLE;
      rx_first_ff <= 16'h0000;
      rx_second_ff <= 16'h0000;
    end else begin
      wide_ff <= wide;
      strobe_ff <= fev;
      if (fev) begin
        v_b1_ff <= tx_b1;
        v_b2_ff <= tx_b2;
        v_b1n_ff <= voice_tx_second[15:8];
        v_b2n_ff <= voice_tx_second[7:0];
        rx_first_ff <= rx_first;
        rx_second_ff <= rx_second;
      end
    end
  end

  // ****************************************
  // Monitor receiver and transmitter
  // ****************************************
  always_comb begin
    logic fail;
    logic tx_done;
    fail = 1'b0;
    tx_done = 1'b0;
    nxt_rx_st = rx_st_ff;
    nxt_tx_st = tx_st_ff;
    nxt_ll = ll_ff;
    nxt_idx = idx_ff;
    nxt_dev = dev_ff;
    nxt_rw = rw_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_hcnt = hcnt_ff;
    nxt_mcnt = mcnt_ff;
    nxt_ecnt = ecnt_ff;
    nxt_seen = seen_ff;
    nxt_mr = mr_ff;
    nxt_mx = mx_ff;
    nxt_mon = mon_ff;
    nxt_abort = 1'b0;
    nxt_eom = 1'b0;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    // Address moves only after the access pulse has used it
    if (wr_ff | rd_ff) begin
      nxt_addr = addr_ff + 8'h01;
    end
    if (rd_ff) begin
      nxt_mon = reg_rdata;
    end
    if (fev) begin
      unique case (tx_st_ff)
        TX_IDLE: begin
          nxt_mx = 1'b1;
          nxt_mon = MON_IDLE;
        end
        TX_SEND: begin
          nxt_mx = 1'b0;
          // Collision is judged only once the host acts as receiver
          if (seen_ff && collision) begin
            nxt_abort = 1'b1;
            nxt_tx_st = TX_END;
            nxt_ecnt = 2'h0;
            nxt_mx = 1'b1;
            nxt_mon = MON_IDLE;
          end else if (dn_mr) begin
            nxt_seen = 1'b1;
          end else if (seen_ff) begin
            nxt_tx_st = TX_GAP;
            nxt_mx = 1'b1;
            nxt_mon = MON_IDLE;
          end
        end
        TX_GAP: begin
          if (reg_addr_valid) begin
            nxt_rd = 1'b1;
            nxt_tx_st = TX_SEND;
            nxt_seen = 1'b0;
          end else begin
            nxt_abort = 1'b1;
            nxt_tx_st = TX_END;
            nxt_ecnt = 2'h0;
          end
        end
        TX_END: begin
          nxt_mx = 1'b1;
          nxt_mon = MON_IDLE;
          if (ecnt_ff == EOM_LAST) begin
            nxt_tx_st = TX_IDLE;
            tx_done = 1'b1;
          end else begin
            nxt_ecnt = ecnt_ff + 2'h1;
          end
        end
      endcase
      unique case (rx_st_ff)
        RX_IDLE: begin
          nxt_mr = 1'b1;
          if (!dn_mx) begin
            nxt_ll = dn_mon;
            nxt_idx = IDX_DEV;
            nxt_mcnt = 2'h0;
            nxt_rx_st = RX_CHECK;
          end
        end
        RX_CHECK: begin
          nxt_mr = 1'b1;
          if (dn_mx) begin
            fail = 1'b1;
          end else if (same_copy) begin
            nxt_mr = 1'b0;
            nxt_hcnt = 2'h0;
            nxt_rx_st = RX_ACK;
            unique case (idx_ff)
              IDX_DEV: begin
                if (dev_ok) begin
                  nxt_dev = dn_mon;
                  nxt_idx = IDX_CMD;
                end else begin
                  fail = 1'b1;
                end
              end
              IDX_CMD: begin
                if (cmd_ok) begin
                  nxt_rw = dn_mon[CMD_RW];
                  nxt_idx = IDX_ADDR;
                end else begin
                  fail = 1'b1;
                end
              end
              IDX_ADDR: begin
                nxt_addr = dn_mon;
                nxt_idx = IDX_DATA;
                if (rw_ff) begin
                  nxt_rx_st = RX_READ;
                  nxt_tx_st = TX_SEND;
                  nxt_seen = 1'b0;
                  nxt_mon = dev_ff;
                end
              end
              IDX_DATA: begin
                if (reg_addr_valid) begin
                  nxt_wr = 1'b1;
                  nxt_wdata = dn_mon;
                end else begin
                  fail = 1'b1;
                end
              end
            endcase
          end else if (mcnt_ff == MISS_LAST) begin
            fail = 1'b1;
          end else begin
            nxt_ll = dn_mon;
            nxt_mcnt = mcnt_ff + 2'h1;
          end
        end
        RX_ACK: begin
          nxt_mr = 1'b0;
          if (dn_mx) begin
            if (hcnt_ff == EOM_LAST) begin
              nxt_eom = 1'b1;
              nxt_mr = 1'b1;
              nxt_rx_st = RX_IDLE;
            end else begin
              nxt_hcnt = hcnt_ff + 2'h1;
            end
          end else if (hcnt_ff != 2'h0) begin
            nxt_ll = dn_mon;
            nxt_mr = 1'b1;
            nxt_mcnt = 2'h0;
            nxt_rx_st = RX_CHECK;
          end
        end
        RX_READ: begin
          if (tx_done) begin
            nxt_mr = 1'b1;
            nxt_hcnt = 2'h0;
            nxt_rx_st = RX_DRAIN;
          end
        end
        RX_DRAIN: begin
          nxt_mr = 1'b1;
          if (!dn_quiet) begin
            nxt_hcnt = 2'h0;
          end else if (hcnt_ff == EOM_LAST) begin
            nxt_eom = 1'b1;
            nxt_rx_st = RX_IDLE;
          end else begin
            nxt_hcnt = hcnt_ff + 2'h1;
          end
        end
      endcase
      if (fail) begin
        nxt_abort = 1'b1;
        nxt_mr = 1'b1;
        nxt_hcnt = 2'h0;
        nxt_rx_st = RX_DRAIN;
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_ff <= RX_IDLE;
      tx_st_ff <= TX_IDLE;
      mr_ff <= 1'b1;
      mx_ff <= 1'b1;
      mon_ff <= MON_IDLE;
      ll_ff <= MON_IDLE;
      idx_ff <= IDX_DEV;
      dev_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      hcnt_ff <= 2'h0;
      mcnt_ff <= 2'h0;
      ecnt_ff <= 2'h0;
      seen_ff <= 1'b0;
      abort_ff <= 1'b0;
      eom_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      tx_st_ff <= nxt_tx_st;
      mr_ff <= nxt_mr;
      mx_ff <= nxt_mx;
      mon_ff <= nxt_mon;
      ll_ff <= nxt_ll;
      idx_ff <= nxt_idx;
      dev_ff <= nxt_dev;
      rw_ff <= nxt_rw;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      hcnt_ff <= nxt_hcnt;
      mcnt_ff <= nxt_mcnt;
      ecnt_ff <= nxt_ecnt;
      seen_ff <= nxt_seen;
      abort_ff <= nxt_abort;
      eom_ff <= nxt_eom;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_addr = addr_ff;
  assign reg_wdata = wdata_ff;
  assign reg_write = wr_ff;
  assign reg_read = rd_ff;
  assign abort_indication = abort_ff;
  assign end_of_message = eom_ff;
  assign message_active = rx_st_ff != RX_IDLE;
  assign voice_rx_first = rx_first_ff;
  assign voice_rx_second = rx_second_ff;
  assign voice_strobe = strobe_ff;
endmodule

// ---- design/gcm_pkg.sv ----
// Shared constants and types for the highway monitor channel engine
package gcm_pkg;

  // ****************************************
  // Highway frame layout
  // ****************************************
  localparam int FRAME_BITS = 256;
  localparam int SUB_BITS = 32;
  localparam int LINK_BYTES = 6;
  localparam int FRAME_NS = 125000;
  localparam int CLK_NS = 50;
  localparam int FRAME_CLKS = FRAME_NS / CLK_NS;
  // Byte lanes shared with the link framer
  localparam int LB_B1 = 0;
  localparam int LB_B2 = 1;
  localparam int LB_MON = 2;
  localparam int LB_SC = 3;
  localparam int LB_B1N = 4;
  localparam int LB_B2N = 5;

  // ****************************************
  // Signal/control byte and monitor byte
  // ****************************************
  localparam int HS_MR = 1;
  localparam int HS_MX = 0;
  localparam logic [5:0] CI_IDLE = 6'h3F;
  localparam logic [7:0] MON_IDLE = 8'hFF;
  localparam logic [7:0] BYTE_IDLE = 8'hFF;

  // ****************************************
  // Message layout and frame counts
  // ****************************************
  localparam logic [2:0] DEV_TOP = 3'h4;
  localparam logic [1:0] DEV_MID = 2'h0;
  localparam int DEV_NORMAL = 0;
  localparam logic [6:0] CMD_REG = 7'h01;
  localparam int CMD_RW = 7;
  localparam logic [1:0] IDX_DEV = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_ADDR = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam logic [1:0] EOM_LAST = 2'h1;
  localparam logic [1:0] MISS_LAST = 2'h1;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {RX_IDLE, RX_CHECK, RX_ACK, RX_READ, RX_DRAIN} gcm_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP, TX_END} gcm_tx_state_t;

endpackage

// ---- design/gcm_toggle_sync.sv ----
// Toggle to pulse crossing into the system clock domain
`timescale 1ns/1ps
module gcm_toggle_sync import gcm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Crossing
  input wire logic tgl_in,
  output logic pulse
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= tgl_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Only the second and third stages feed the edge detector
  assign pulse = sync_ff ^ last_ff;
endmodule

// ---- design/gcm_link_framer.sv ----
// Highway bit framer on the link clock: slot timing, serialiser and deserialiser
`timescale 1ns/1ps
module gcm_link_framer import gcm_pkg::*; (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic reset,
  // Highway pins
  input wire logic frame_sync,
  input wire logic highway_receive_line,
  output logic highway_transmit_line,
  output logic highway_transmit_oe,
  input wire logic [2:0] subframe_sel,
  // From the system domain
  input wire logic wide_mode,
  input wire logic [47:0] up_bytes,
  // To the system domain
  output logic [47:0] dn_bytes,
  output logic frame_tgl
);
  logic [2:0] sel_meta_ff;
  logic [2:0] sel_ff;
  logic wide_meta_ff;
  logic wide_ff;
  logic fs_ff;
  logic [7:0] cnt_ff;
  logic [6:0] shift_ff;
  logic tx_ff;
  logic oe_ff;
  logic tgl_ff;
  logic [7:0] snap_ff [0:LINK_BYTES-1];
  logic [7:0] dn_ff [0:LINK_BYTES-1];

  // ****************************************
  // Slot decode
  // ****************************************
  wire fs_rise = frame_sync & ~fs_ff;
  wire [7:0] cur = fs_rise ? 8'h00 : cnt_ff;
  wire [7:0] npos = cur + 8'h01;
  wire [7:0] base = {sel_ff, 5'h00};
  wire [7:0] rel = cur - base;
  wire [7:0] nrel = npos - base;
  wire rx_own = rel[7:5] == 3'h0;
  wire rx_nxt = wide_ff && rel[7:5] == 3'h1 && !rel[4];
  wire [2:0] rx_idx = {rel[5], rel[4:3]};
  wire byte_done = (rx_own | rx_nxt) && rel[2:0] == 3'h7;
  wire [7:0] rx_byte = {shift_ff, highway_receive_line};
  wire tx_own = nrel[7:5] == 3'h0;
  wire tx_nxt = wide_ff && nrel[7:5] == 3'h1 && !nrel[4];
  wire [2:0] tx_idx = {nrel[5], nrel[4:3]};
  wire [2:0] tx_bit = 3'h7 - nrel[2:0];
  // Upstream words are settled most of a frame before this load point
  wire snap_load = nrel == 8'hFF;
  wire frame_end = rel == {2'h0, wide_ff, 5'h1F};

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      sel_meta_ff <= 3'h0;
      sel_ff <= 3'h0;
      wide_meta_ff <= 1'b0;
      wide_ff <= 1'b0;
      fs_ff <= 1'b0;
      cnt_ff <= 8'h00;
      shift_ff <= 7'h7F;
      tx_ff <= 1'b1;
      oe_ff <= 1'b0;
      tgl_ff <= 1'b0;
    end else begin
      sel_meta_ff <= subframe_sel;
      sel_ff <= sel_meta_ff;
      wide_meta_ff <= wide_mode;
      wide_ff <= wide_meta_ff;
      fs_ff <= frame_sync;
      cnt_ff <= npos;
      shift_ff <= rx_byte[6:0];
      tx_ff <= snap_ff[tx_idx][tx_bit];
      oe_ff <= tx_own | tx_nxt;
      if (frame_end) begin
        tgl_ff <= ~tgl_ff;
      end
    end
  end

  // ****************************************
  // Per-byte capture and snapshot
  // ****************************************
  for (genvar i = 0; i < LINK_BYTES; i++) begin : g_lane
    always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
        snap_ff[i] <= BYTE_IDLE;
        dn_ff[i] <= BYTE_IDLE;
      end else begin
        if (snap_load) begin
          snap_ff[i] <= up_bytes[8*i +: 8];
        end
        if (byte_done && rx_idx == 3'(i)) begin
          dn_ff[i] <= rx_byte;
        end
      end
    end
    assign dn_bytes[8*i +: 8] = dn_ff[i];
  end

  assign highway_transmit_line = tx_ff;
  assign highway_transmit_oe = oe_ff;
  assign frame_tgl = tgl_ff;
endmodule

// ---- verification/gcm_monitor_engine_checker.sv ----
// Port assertions for the monitor channel engine
`timescale 1ns/1ps
module gcm_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_addr_valid,
  input wire logic abort_indication,
  input wire logic end_of_message,
  input wire logic message_active,
  input wire logic voice_strobe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_wr_addr_step: assert property (reg_write |=> reg_addr == $past(reg_addr) + 8'h01)
    else $error("no step after write");
  a_rd_addr_step: assert property (reg_read |=> reg_addr == $past(reg_addr) + 8'h01)
    else $error("no step after read");
  a_wr_valid_addr: assert property (reg_write |-> reg_addr_valid)
    else $error("write to bad address");
  a_rd_valid_addr: assert property (reg_read |-> reg_addr_valid)
    else $error("read of bad address");
  a_access_gap: assert property ((reg_write || reg_read) |=> !(reg_write || reg_read) [*8])
    else $error("accesses too close");
  a_access_active: assert property ((reg_write || reg_read) |-> message_active)
    else $error("access while idle");
  a_abort_pulse: assert property (abort_indication |=> !abort_indication)
    else $error("abort not a pulse");
  a_eom_idle: assert property (end_of_message |-> ##[0:4] !message_active)
    else $error("no idle after end");
  a_strobe_gap: assert property (voice_strobe |=> !voice_strobe [*8])
    else $error("frame events too close");
endmodule
bind gcm_monitor_engine gcm_checker i_gcm_checker (.clk, .reset, .reg_addr, .reg_write,
  .reg_read, .reg_addr_valid, .abort_indication, .end_of_message, .message_active,
  .voice_strobe);

// ---- verification/gcm_host_model.sv ----
// Host side of the highway: frame timing and serial byte lanes
`timescale 1ns/1ps
module gcm_host_model (
  // Highway
  input wire logic link_clk,
  output logic frame_sync,
  output logic hwy_dn,
  input wire logic hwy_up,
  // Bytes of sub-frames 0 and 1
  input wire logic [47:0] dn,
  output logic [47:0] up,
  output int fcount
);
  logic [7:0] b_ff = 8'h00;
  logic [47:0] dn_ff = '1;
  logic [47:0] sh_ff = '1;
  initial up = '1;
  initial fcount = 0;
  assign frame_sync = (b_ff == 8'h00);
  // Foreign slots toggle so stale data never looks valid
  assign hwy_dn = (b_ff < 8'h30) ? dn_ff[8'h2F - b_ff] : b_ff[0];
  always @(posedge link_clk) begin
    b_ff <= b_ff + 8'h01;
    if (b_ff == 8'hFF) dn_ff <= dn;
    if (b_ff == 8'h80) begin
      up <= sh_ff;
      fcount <= fcount + 1;
    end
  end
  // Upstream bits stand in the same bit times as downstream ones; take them mid bit
  always @(negedge link_clk) begin
    if (b_ff <= 8'h2F) sh_ff[8'h2F - b_ff] <= hwy_up;
  end
endmodule

// ---- verification/tb_gcm_monitor_engine.sv ----
// Self-checking bench for the monitor channel engine
`timescale 1ns/1ps
module tb_gcm_monitor_engine;
  logic clk = 0, link_clk = 0, reset = 1, rate_16k = 0, linear_16 = 0;
  logic [2:0] subframe_sel = 3'h0;
  logic [15:0] voice_tx_first = 16'h1234, voice_tx_second = 16'hABCD;
  logic frame_sync, highway_receive_line, highway_transmit_line, highway_transmit_oe;
  logic [15:0] voice_rx_first, voice_rx_second;
  logic voice_strobe, reg_write, reg_read, abort_indication, end_of_message, message_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, regs [32] = '{default: 8'h00};
  logic reg_addr_valid;
  logic [47:0] dn = '1, up;
  logic [7:0] got [$];
  int fcount, n_fail = 0, checked = 0, n_abt = 0, n_acc = 0, n_eom = 0, a0, w0, e0, cyc = 0;
  int n_ack = 0;
  // Rows: rate, width, expected B1 B2 of own and next sub-frame
  logic [33:0] vrow [3] = '{{2'b10, 32'h12AB_FFFF}, {2'b01, 32'h1234_FFFF},
    {2'b11, 32'h1234_ABCD}};
  // Upstream line is open drain with a pull-up
  wire hwy_up = highway_transmit_oe ? highway_transmit_line : 1'b1;
  assign reg_rdata = regs[reg_addr[4:0]];
  assign reg_addr_valid = reg_addr < 8'h12;
  always #25 clk = ~clk;
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  gcm_monitor_engine i_gcm_monitor_engine (.clk, .reset, .link_clk, .frame_sync,
    .highway_receive_line, .highway_transmit_line, .highway_transmit_oe, .subframe_sel,
    .rate_16k, .linear_16, .voice_tx_first, .voice_tx_second, .voice_rx_first,
    .voice_rx_second, .voice_strobe, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .reg_addr_valid, .abort_indication, .end_of_message, .message_active);
  gcm_host_model i_gcm_host_model (.link_clk, .frame_sync, .hwy_dn(highway_receive_line),
    .hwy_up, .dn, .up, .fcount);
  always @(posedge clk) begin
    cyc++;
    n_abt += abort_indication;
    n_eom += end_of_message;
    n_acc += reg_write | reg_read;
    if (reg_write) regs[reg_addr[4:0]] <= reg_wdata;
    if (cyc == 98000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [47:0] got_v, exp_v);
    checked++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  // Set the bytes of the next frame, wait for the upstream snapshot
  task automatic frm(input logic [7:0] mon, sc);
    @(posedge clk) dn <= {8'h5E, 8'h6F, mon, sc, 8'h70, 8'h81};
    @(fcount);
  endtask
  // Each byte in two frames, then one gap frame that anticipates the acknowledge
  task automatic msg(input logic [7:0] q[$], input bit cl);
    foreach (q[i]) begin
      frm(q[i], 8'hFE);
      chk(up[31:24], 8'hFF);
      frm(q[i], 8'hFE);
      frm(q[i], 8'hFF);
      n_ack += !up[17];
    end
    if (cl) repeat (3) frm(8'hFF, 8'hFF);
  endtask
  // Host acknowledges each device byte, sending col while the device transmits
  task automatic rd(input logic [7:0] col);
    logic pmx;
    pmx = 1'b1;
    got = {};
    repeat (16) begin
      if (pmx && !up[16]) got.push_back(up[31:24]);
      pmx = up[16];
      frm(up[16] ? 8'hFF : col, {6'h3F, up[16], 1'b1});
    end
    repeat (3) frm(8'hFF, 8'hFF);
  endtask
  task automatic snap();
    a0 = n_abt;
    w0 = n_acc;
    e0 = n_eom;
  endtask
  function automatic logic [15:0] dl();
    return {8'(n_abt - a0), 8'(n_acc - w0)};
  endfunction
  task automatic finish_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (3) frm(8'hFF, 8'hFF);
    chk({up[31:16], reg_addr, 7'h00, message_active}, 32'hFFFF_0000);
    foreach (vrow[i]) begin
      @(posedge clk) {rate_16k, linear_16} <= vrow[i][33:32];
      repeat (4) frm(8'hFF, 8'hFF);
      chk({up[47:32], up[15:0]}, vrow[i][31:0]);
      chk(voice_rx_first[15:8], 8'h5E);
    end
    chk(voice_rx_second, 16'h7081);
    snap();
    msg('{8'h99, 8'h01, 8'h10, 8'hA5, 8'h5A, 8'hC3}, 1);
    chk({regs[16], regs[17], regs[18], dl()}, 40'hA5_5A00_0102);
    snap();
    msg('{8'h99, 8'h01, 8'h05, 8'h3C}, 1);
    chk({regs[5], dl(), 8'(n_eom - e0), 7'h00, message_active}, 40'h3C_0001_0100);
    chk(48'(n_ack), 48'h0000_0000_0009);
    snap();
    msg('{8'h99, 8'h02}, 1);
    chk(dl(), 16'h0100);
    snap();
    frm(8'h99, 8'hFE);
    repeat (4) frm(8'hFF, 8'hFF);
    chk(dl(), 16'h0100);
    snap();
    msg('{8'h99, 8'h81, 8'h10}, 0);
    rd(8'hFF);
    chk({got[0], got[1], got[2], 8'(got.size()), dl()}, 48'h99A5_5A03_0102);
    snap();
    msg('{8'h99, 8'h81, 8'h10}, 0);
    rd(8'h00);
    chk(8'(n_abt - a0), 8'h01);
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    chk({reg_addr, 7'h00, message_active}, 16'h0000);
    finish_test();
  end
endmodule
